// ==== rtl/ops_divider.sv ====
`default_nettype none

module ops_divider #(
	parameter int unsigned W = ops_pkg::DIV_W
) (
	input  wire logic         clk_in,    // Master clock
	input  wire logic         rst_in,    // Sync reset, high
	ops_mclk_if.snk           mclk,      // Prescaled clock in
	input  wire logic         clear_in,  // Hold counter at zero
	input  wire logic [W-1:0] ratio_in,  // Divide ratio minus one
	output logic              div_out    // Divided waveform
);
	import ops_pkg::*;

	logic [W-1:0] cnt;
	logic         act;

	// Clear beats a tick in the same cycle, so a held output never restarts
	always_ff @(posedge clk_in) begin
		if (rst_in || clear_in) begin
			cnt <= '0;
			act <= 1'b0;
		end else if (mclk.tick) begin
			if (!act) begin
				act <= 1'b1;
				cnt <= '0;
			end else if (cnt >= ratio_in) begin
				cnt <= '0;
			end else begin
				cnt <= W'(cnt + 1'b1);
			end
		end
	end

	// Divide-by-one passes the prescaled clock straight through
	always_comb begin
		if (!act) begin
			div_out = 1'b0;
		end else if (ratio_in == '0) begin
			div_out = mclk.level;
		end else begin
			div_out = (cnt <= (ratio_in >> 1));
		end
	end

endmodule : ops_divider

`default_nettype wire

// ==== rtl/ops_mclk_if.sv ====
`default_nettype none

interface ops_mclk_if;
	logic tick;   // One cycle at each prescaled-clock rising edge
	logic level;  // Prescaled clock waveform

	modport src (output tick, output level);
	modport snk (input tick, input level);
endinterface : ops_mclk_if

`default_nettype wire

// ==== rtl/ops_pkg.sv ====
`default_nettype none

package ops_pkg;

	// Clock timebase
	localparam int unsigned CLK_PERIOD_NS  = 40;

	// Field widths of the programmed ratios
	localparam int unsigned PRE_W          = 8;
	localparam int unsigned DIV_W          = 10;

	// Settling wait in prescaled-clock rising edges
	localparam int unsigned STAB_TICKS     = 256;
	localparam int unsigned STAB_W         = 9;

	// Reset stage that precedes the oscillator start
	localparam int unsigned POR_TIME_NS    = 1000;
	localparam int unsigned POR_CYC        = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Longest time from power-down pin fall to both outputs floating
	localparam int unsigned PD_LIMIT_NS    = 1000000;
	localparam int unsigned PD_LIMIT_CYC   = PD_LIMIT_NS / CLK_PERIOD_NS;

	// Longest time from supply to oscillation, for reference
	localparam int unsigned PWRUP_LIMIT_NS = 1000000;

	// Reset values of the filtered pin levels
	localparam logic        GATE_RST       = 1'b0;
	localparam logic        PDN_RST        = 1'b0;

	typedef enum {
		ST_POR,
		ST_OFF,
		ST_WAIT_GATE,
		ST_STAB,
		ST_LOAD,
		ST_EN_REF,
		ST_EN_MAIN,
		ST_RUN,
		ST_PD_MAIN,
		ST_PD_REF
	} ops_state_e;

endpackage : ops_pkg

`default_nettype wire

// ==== rtl/ops_prescaler.sv ====
`default_nettype none

module ops_prescaler #(
	parameter int unsigned W = ops_pkg::PRE_W
) (
	input  wire logic         clk_in,    // Master clock
	input  wire logic         rst_in,    // Sync reset, high
	input  wire logic         run_in,    // Oscillator running
	input  wire logic [W-1:0] ratio_in,  // Divide ratio minus one
	ops_mclk_if.src           mclk       // Prescaled clock out
);
	import ops_pkg::*;

	logic [W-1:0] cnt;

	// Wrap on >= so a ratio shrinking mid-count cannot strand the counter
	always_ff @(posedge clk_in) begin
		if (rst_in || !run_in) begin
			cnt        <= '0;
			mclk.tick  <= 1'b0;
			mclk.level <= 1'b0;
		end else if (cnt >= ratio_in) begin
			cnt        <= '0;
			mclk.tick  <= 1'b1;
			mclk.level <= 1'b1;
		end else begin
			cnt        <= W'(cnt + 1'b1);
			mclk.tick  <= 1'b0;
			mclk.level <= (W'(cnt + 1'b1) <= (ratio_in >> 1));
		end
	end

endmodule : ops_prescaler

`default_nettype wire

// ==== rtl/ops_sequencer.sv ====
// Functional notes
// - Leaving power-down: enable reference output first if configured, then main output.
// - At supply-on run a reset stage, then start the oscillator.
// - After reset stage force both ratios to maximum, wait 256 prescaled cycles.
// - After the wait load programmed prescaler and divider ratios.
// - Last power-on steps: reference output if configured, then main output.
// - Gate low at start postpones the settling wait until gate rises.
// - Gate dropped during the wait keeps main output low afterwards.
// - Gate never affects reference output while running.
// - Gate low throughout power-up: reference output never starts.
// - Main output first rises one to two prescaled periods after gate rises.
// - Main output falls within one high pulse (plus one period when divide-by-one).
// - Power-down fall floats main output within one high pulse, at most 1 ms.
// - Power-down fall floats reference output within the same bounds.
// - Power-down rise gives first edges within 256 prescaled periods.
// - After supply-on each output rises within 256 periods past reset stage.
// - Supply to oscillation typically 0.1 ms, never over 1 ms.
// - Power-down: gate main off, clear dividers, float main, then float reference and stop clock in one cycle, halt.
// - Gate low holds main low at once or at its next fall; divider cleared.
// - Power-down release: start oscillator, maximum ratios, wait 256, restore ratios.
// - Gate sampled on prescaled clock rising edges, combined with divider output.
`default_nettype none

module ops_sequencer #(
	parameter int unsigned PRE_W        = ops_pkg::PRE_W,
	parameter int unsigned DIV_W        = ops_pkg::DIV_W,
	parameter int unsigned POR_CYC      = ops_pkg::POR_CYC,
	parameter int unsigned PD_LIMIT_CYC = ops_pkg::PD_LIMIT_CYC
) (
	input  wire logic             clk_in,                            // Master clock
	input  wire logic             rst_in,                            // Supply-on reset
	input  wire logic             gate_pin_in,                       // Output gate pin
	input  wire logic             pdn_n_pin_in,                      // Power-down pin, low
	input  wire logic [PRE_W-1:0] prog_prescale_in,                  // Stored M minus one
	input  wire logic [DIV_W-1:0] prog_divide_in,                    // Stored N minus one
	input  wire logic             reference_disable_bit_in,          // Reference off
	output logic                  main_divided_output_out,           // Main output level
	output logic                  main_divided_output_oe_out,        // Main output drive
	output logic                  reference_prescaled_output_out,    // Reference level
	output logic                  reference_prescaled_output_oe_out, // Reference drive
	output logic                  osc_run_out,                       // Oscillator on
	output logic                  ratios_loaded_out                  // Programmed ratios
);
	import ops_pkg::*;

	localparam int unsigned TMR_W = $clog2(PD_LIMIT_CYC + POR_CYC + 2);

	ops_mclk_if mclk ();

	ops_state_e       state;
	logic [TMR_W-1:0] tmr;
	logic [STAB_W-1:0] stab_cnt;
	logic             gate_s1;
	logic             gate_s2;
	logic             gate_s3;
	logic             gate_f;
	logic             pdn_s1;
	logic             pdn_s2;
	logic             pdn_s3;
	logic             pdn_f;
	logic             gate_smp;
	logic             osc_run;
	logic             use_prog;
	logic             ref_en;
	logic             ref_drive;
	logic             main_en;
	logic             main_drive;
	logic             div_out;
	logic             div_clear;
	logic             pd_timeout;
	logic [PRE_W-1:0] pre_ratio;
	logic [DIV_W-1:0] div_ratio;

	// Pin synchronisers: a level counts once the second and third stages agree
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			gate_s1 <= GATE_RST;
			gate_s2 <= GATE_RST;
			gate_s3 <= GATE_RST;
			gate_f  <= GATE_RST;
		end else begin
			gate_s1 <= gate_pin_in;
			gate_s2 <= gate_s1;
			gate_s3 <= gate_s2;
			if (gate_s2 == gate_s3) begin
				gate_f <= gate_s3;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pdn_s1 <= PDN_RST;
			pdn_s2 <= PDN_RST;
			pdn_s3 <= PDN_RST;
			pdn_f  <= PDN_RST;
		end else begin
			pdn_s1 <= pdn_n_pin_in;
			pdn_s2 <= pdn_s1;
			pdn_s3 <= pdn_s2;
			if (pdn_s2 == pdn_s3) begin
				pdn_f <= pdn_s3;
			end
		end
	end

	// Maximum ratios until the settling wait is over
	assign pre_ratio = use_prog ? prog_prescale_in : '1;
	assign div_ratio = use_prog ? prog_divide_in : '1;

	ops_prescaler #(
		.W        (PRE_W)
	) u_prescaler (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.run_in   (osc_run),
		.ratio_in (pre_ratio),
		.mclk     (mclk.src)
	);

	ops_divider #(
		.W        (DIV_W)
	) u_divider (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.mclk     (mclk.snk),
		.clear_in (div_clear),
		.ratio_in (div_ratio),
		.div_out  (div_out)
	);

	// Gate is resampled only at prescaled rising edges; power-down looks like a low gate
	always_ff @(posedge clk_in) begin
		if (rst_in || state == ST_OFF) begin
			gate_smp <= 1'b0;
		end else if (mclk.tick) begin
			gate_smp <= gate_f && pdn_f;
		end
	end

	// Clear only once the divided level is low, so a high pulse is never cut
	assign div_clear = !gate_smp && !div_out;

	// Timer serves the reset stage and the power-down bound
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tmr <= '0;
		end else if (state == ST_POR || state == ST_PD_MAIN || state == ST_PD_REF) begin
			if (tmr != '1) begin
				tmr <= TMR_W'(tmr + 1'b1);
			end
		end else begin
			tmr <= '0;
		end
	end

	assign pd_timeout = (tmr >= TMR_W'(PD_LIMIT_CYC - 1));

	// Settling wait counted in prescaled rising edges
	always_ff @(posedge clk_in) begin
		if (rst_in || state != ST_STAB) begin
			stab_cnt <= '0;
		end else if (mclk.tick) begin
			stab_cnt <= STAB_W'(stab_cnt + 1'b1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state      <= ST_POR;
			osc_run    <= 1'b0;
			use_prog   <= 1'b0;
			ref_en     <= 1'b0;
			ref_drive  <= 1'b0;
			main_en    <= 1'b0;
			main_drive <= 1'b0;
		end else begin
			case (state)
				ST_POR: begin
					// Oscillator held off while the reset stage runs
					if (tmr >= TMR_W'(POR_CYC - 1)) begin
						osc_run <= 1'b1;
						state   <= ST_WAIT_GATE;
					end
				end
				ST_OFF: begin
					if (pdn_f) begin
						osc_run  <= 1'b1;
						use_prog <= 1'b0;
						state    <= ST_WAIT_GATE;
					end
				end
				ST_WAIT_GATE: begin
					if (!pdn_f) begin
						state <= ST_PD_MAIN;
					end else if (gate_f) begin
						state <= ST_STAB;
					end
				end
				ST_STAB: begin
					if (!pdn_f) begin
						state <= ST_PD_MAIN;
					end else if (mclk.tick && stab_cnt == STAB_W'(STAB_TICKS - 1)) begin
						state <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					use_prog <= 1'b1;
					state    <= ST_EN_REF;
				end
				ST_EN_REF: begin
					// Waiting for a low phase keeps the first reference pulse whole
					if (!pdn_f) begin
						state <= ST_PD_MAIN;
					end else if (reference_disable_bit_in) begin
						state <= ST_EN_MAIN;
					end else if (!mclk.level || pre_ratio == '0) begin
						ref_en    <= 1'b1;
						ref_drive <= 1'b1;
						state     <= ST_EN_MAIN;
					end
				end
				ST_EN_MAIN: begin
					if (!pdn_f) begin
						state <= ST_PD_MAIN;
					end else if (!div_out || (pre_ratio == '0 && div_ratio == '0)) begin
						// Overall divide-by-one has no low phase, so it must not stall here
						main_en    <= 1'b1;
						main_drive <= 1'b1;
						state      <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!pdn_f) begin
						state <= ST_PD_MAIN;
					end
				end
				ST_PD_MAIN: begin
					if (!div_out || pd_timeout) begin
						main_en    <= 1'b0;
						main_drive <= 1'b0;
						state      <= ST_PD_REF;
					end
				end
				ST_PD_REF: begin
					if (!mclk.level || pd_timeout) begin
						ref_en    <= 1'b0;
						ref_drive <= 1'b0;
						osc_run   <= 1'b0;
						use_prog  <= 1'b0;
						state     <= ST_OFF;
					end
				end
				default: begin
					state <= ST_POR;
				end
			endcase
		end
	end

	// Pin drivers registered so no combinational glitch reaches them
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			main_divided_output_out           <= 1'b0;
			main_divided_output_oe_out        <= 1'b0;
			reference_prescaled_output_out    <= 1'b0;
			reference_prescaled_output_oe_out <= 1'b0;
			osc_run_out                       <= 1'b0;
			ratios_loaded_out                 <= 1'b0;
		end else begin
			main_divided_output_out           <= main_en && div_out;
			main_divided_output_oe_out        <= main_drive;
			reference_prescaled_output_out    <= ref_en && mclk.level;
			reference_prescaled_output_oe_out <= ref_drive;
			osc_run_out                       <= osc_run;
			ratios_loaded_out                 <= use_prog;
		end
	end

endmodule : ops_sequencer

`default_nettype wire

// ==== verif/ops_board_model.sv ====
`default_nettype none

module ops_board_model (
	input  wire logic clk_in,        // Board clock
	input  wire logic gate_req_in,   // Wanted gate level
	input  wire logic pdn_req_in,    // Wanted run state
	output var  logic gate_pin_out,  // Output gate pin
	output var  logic pdn_n_pin_out  // Power-down pin, low
);
	timeunit 1ns;
	timeprecision 1ns;

	initial gate_pin_out = 1'b1;
	initial pdn_n_pin_out = 1'b1;

	// Skewed off the edge: the pins are asynchronous to the device
	always @(posedge clk_in) begin
		gate_pin_out <= #13 gate_req_in;
		pdn_n_pin_out <= #13 pdn_req_in;
	end
endmodule : ops_board_model

`default_nettype wire

// ==== verif/ops_checker.sv ====
`default_nettype none

module ops_checker #(
	parameter int unsigned PRE_W        = 8,
	parameter int unsigned DIV_W        = 10,
	parameter int unsigned PD_LIMIT_CYC = 200
) (
	input wire logic             clk_in,                            // Master clock
	input wire logic             rst_in,                            // Supply-on reset
	input wire logic             gate_pin_in,                       // Output gate pin
	input wire logic             pdn_n_pin_in,                      // Power-down pin, low
	input wire logic [PRE_W-1:0] prog_prescale_in,                  // Stored M minus one
	input wire logic [DIV_W-1:0] prog_divide_in,                    // Stored N minus one
	input wire logic             reference_disable_bit_in,          // Reference off
	input wire logic             main_divided_output_out,           // Main level
	input wire logic             main_divided_output_oe_out,        // Main drive
	input wire logic             reference_prescaled_output_out,    // Reference level
	input wire logic             reference_prescaled_output_oe_out, // Reference drive
	input wire logic             osc_run_out,                       // Oscillator on
	input wire logic             ratios_loaded_out                  // Programmed ratios
);
	timeunit 1ns;
	timeprecision 1ns;

	localparam int TM_MAX    = 2 ** PRE_W;
	localparam int PD_MAX    = PD_LIMIT_CYC + 8;
	localparam int EN_MAX    = 3 * TM_MAX + 6;
	localparam int GATE_HOLD = 2 * TM_MAX + 6;
	localparam int STAB_MIN  = 255 * TM_MAX;
	localparam int STAB_MAX  = 258 * TM_MAX + 8;

	logic [15:0] low_cnt;
	logic [15:0] stab_cnt;
	logic        stab_on;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	always_ff @(posedge clk_in) begin
		if (rst_in || gate_pin_in)
			low_cnt <= 16'h0000;
		else if (low_cnt != 16'hFFFF)
			low_cnt <= low_cnt + 16'h0001;
	end

	// Raw gate leads the filtered one, so the count can only run long
	always_ff @(posedge clk_in) begin
		if (rst_in || !osc_run_out || !pdn_n_pin_in)
			stab_on <= 1'b0;
		else if (gate_pin_in)
			stab_on <= 1'b1;
	end

	always_ff @(posedge clk_in) begin
		if (!stab_on)
			stab_cnt <= 16'h0000;
		else if (!ratios_loaded_out)
			stab_cnt <= stab_cnt + 16'h0001;
	end

	sequence s_ref_ready;
		ratios_loaded_out && (reference_prescaled_output_oe_out || reference_disable_bit_in);
	endsequence

	sequence s_main_quiet;
		!$rose(main_divided_output_out) [*4];
	endsequence

	chk_reset_quiet: assert property ($fell(rst_in) |->
		!(main_divided_output_oe_out || reference_prescaled_output_oe_out || osc_run_out
		|| ratios_loaded_out)) else $error("outputs active after reset");
	chk_ref_then_main: assert property (
		$rose(main_divided_output_oe_out) |-> s_ref_ready) else $error("main enabled early");
	chk_load_before_ref: assert property (
		$rose(reference_prescaled_output_oe_out) |-> ratios_loaded_out)
		else $error("reference enabled before load");
	chk_stab_length: assert property ($rose(ratios_loaded_out) |->
		stab_cnt >= STAB_MIN && stab_cnt <= STAB_MAX) else $error("settling wait length");
	chk_ref_disabled: assert property (
		reference_disable_bit_in |-> !reference_prescaled_output_oe_out)
		else $error("disabled reference driven");
	chk_main_off_first: assert property (
		$fell(reference_prescaled_output_oe_out) |-> !main_divided_output_oe_out)
		else $error("reference floated before main");
	chk_clock_off_last: assert property ($fell(osc_run_out) |->
		!reference_prescaled_output_oe_out && !main_divided_output_oe_out)
		else $error("oscillator stopped while driving");
	chk_pd_float_time: assert property ($fell(pdn_n_pin_in) |-> ##[0:PD_MAX]
		(!main_divided_output_oe_out && !reference_prescaled_output_oe_out))
		else $error("outputs not floated in time");
	chk_gate_holds_low: assert property (
		low_cnt >= GATE_HOLD |-> !$rose(main_divided_output_out))
		else $error("main rose while gated");
	chk_gate_rise_main: assert property ($rose(gate_pin_in) && low_cnt >= GATE_HOLD
		&& main_divided_output_oe_out |-> s_main_quiet ##[1:EN_MAX] $rose(main_divided_output_out))
		else $error("main restart time");
	chk_ref_ignores_gate: assert property (
		reference_prescaled_output_oe_out && pdn_n_pin_in && $stable(pdn_n_pin_in)
		|=> reference_prescaled_output_oe_out) else $error("reference dropped while running");
endmodule : ops_checker

`default_nettype wire

// ==== verif/oscillator_power_sequencer_tb_top.sv ====
`default_nettype none

module oscillator_power_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int unsigned PW  = 2;
	localparam int unsigned DW  = 2;
	localparam int unsigned PDL = 200;
	localparam int          UP  = 1600;

	typedef struct {
		logic [PW-1:0] pre;
		logic [DW-1:0] div;
		logic          dis;
		int            per;
	} ops_row_s;

	ops_row_s      rows [3] = '{'{2'h1, 2'h1, 1'b0, 4}, '{2'h2, 2'h0, 1'b1, 3},
		'{2'h3, 2'h3, 1'b0, 16}};
	logic          clk_in   = 1'b0;
	logic          rst_in   = 1'b1;
	logic          gate_req = 1'b1;
	logic          pdn_req  = 1'b1;
	logic [PW-1:0] pre      = 2'h0;
	logic [DW-1:0] div      = 2'h0;
	logic          dis      = 1'b0;
	logic          gate_pin, pdn_n_pin, m, moe, r, roe, osc, ld;
	int            n_mismatch  = 0;
	int            comparisons = 0;
	int            n;

	initial forever #20 clk_in = ~clk_in;

	ops_board_model ops_board_model_i (.clk_in(clk_in), .gate_req_in(gate_req),
		.pdn_req_in(pdn_req), .gate_pin_out(gate_pin), .pdn_n_pin_out(pdn_n_pin));

	ops_sequencer #(.PRE_W(PW), .DIV_W(DW), .POR_CYC(4), .PD_LIMIT_CYC(PDL)) ops_sequencer_i (
		.clk_in(clk_in), .rst_in(rst_in), .gate_pin_in(gate_pin), .pdn_n_pin_in(pdn_n_pin),
		.prog_prescale_in(pre), .prog_divide_in(div), .reference_disable_bit_in(dis),
		.main_divided_output_out(m), .main_divided_output_oe_out(moe),
		.reference_prescaled_output_out(r), .reference_prescaled_output_oe_out(roe),
		.osc_run_out(osc), .ratios_loaded_out(ld));

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : check

	// Leaves the elapsed cycle count in n
	task automatic wait_lvl(ref logic s, input logic want, input int lim, input string msg);
		for (n = 0; n < lim && s !== want; n++)
			@(negedge clk_in);
		if (s !== want) begin
			check(1'b0, msg);
			tally_and_finish();
		end
	endtask : wait_lvl

	task automatic start(input ops_row_s c, input logic g);
		@(posedge clk_in);
		rst_in   <= 1'b1;
		pre      <= c.pre;
		div      <= c.div;
		dis      <= c.dis;
		gate_req <= g;
		pdn_req  <= 1'b1;
		repeat (3) @(posedge clk_in);
		rst_in <= 1'b0;
		@(negedge clk_in);
	endtask : start

	initial begin
		int k;
		int hi;
		foreach (rows[i]) begin
			start(rows[i], 1'b1);
			wait_lvl(moe, 1'b1, UP, "main never enabled");
			check(roe === ~rows[i].dis && ld === 1'b1, "reference drive");
			wait_lvl(m, 1'b0, 40, "main stuck high");
			wait_lvl(m, 1'b1, 40, "main stuck low");
			wait_lvl(m, 1'b0, 40, "main stuck high");
			k = n;
			wait_lvl(m, 1'b1, 40, "main stuck low");
			check(k + n == rows[i].per, "main period");
			if (!rows[i].dis) begin
				wait_lvl(r, 1'b0, 40, "reference stuck high");
				wait_lvl(r, 1'b1, 40, "reference stuck low");
				wait_lvl(r, 1'b0, 40, "reference stuck high");
				k = n;
				wait_lvl(r, 1'b1, 40, "reference stuck low");
				check(k + n == rows[i].pre + 1, "reference period");
			end else begin
				check(r === 1'b0, "disabled reference toggles");
			end
			$display("row %0d done", i);
		end
		@(posedge clk_in);
		gate_req <= 1'b0;
		repeat (20) @(negedge clk_in);
		hi = 0;
		// Whole reference periods, so the high count is exact
		for (int i = 0; i < 32; i++) begin
			@(negedge clk_in);
			check(m === 1'b0 && roe === 1'b1, "gate low");
			if (r === 1'b1)
				hi++;
		end
		check(hi == 16, "reference gated");
		@(posedge clk_in);
		gate_req <= 1'b1;
		wait_lvl(m, 1'b1, 40, "main not restarted");
		check(n >= 4 && n <= 18, "main restart time");
		$display("gate test done");
		@(posedge clk_in);
		pdn_req <= 1'b0;
		wait_lvl(roe, 1'b0, PDL + 8, "reference still driven");
		check(moe === 1'b0, "main floated first");
		wait_lvl(osc, 1'b0, 20, "oscillator still on");
		repeat (4) @(negedge clk_in);
		check(ld === 1'b0, "ratios back to maximum");
		@(posedge clk_in);
		pdn_req <= 1'b1;
		wait_lvl(roe, 1'b1, UP, "reference not restored");
		k = n;
		wait_lvl(moe, 1'b1, 64, "main not restored");
		check(k + n <= 258 * 4 + 30, "restart time");
		$display("power-down test done");
		@(posedge clk_in);
		rst_in <= 1'b1;
		repeat (2) @(negedge clk_in);
		check({moe, roe, osc, ld} === 4'h0, "outputs in reset");
		start(rows[0], 1'b0);
		repeat (UP) @(negedge clk_in);
		check({moe, roe, ld} === 3'h0, "gate low at power-up");
		@(posedge clk_in);
		gate_req <= 1'b1;
		wait_lvl(roe, 1'b1, UP, "no start after gate rise");
		$display("gate start test done");
		start(rows[0], 1'b1);
		repeat (300) @(negedge clk_in);
		@(posedge clk_in);
		gate_req <= 1'b0;
		wait_lvl(moe, 1'b1, UP, "main never enabled");
		for (int i = 0; i < 40; i++) begin
			@(negedge clk_in);
			check(m === 1'b0, "gated during settling");
		end
		$display("settling gate test done");
		tally_and_finish();
	end
endmodule : oscillator_power_sequencer_tb_top

bind ops_sequencer ops_checker #(.PRE_W(PRE_W), .DIV_W(DIV_W), .PD_LIMIT_CYC(PD_LIMIT_CYC))
	ops_checker_i (.clk_in(clk_in), .rst_in(rst_in), .gate_pin_in(gate_pin_in),
	.pdn_n_pin_in(pdn_n_pin_in), .prog_prescale_in(prog_prescale_in),
	.prog_divide_in(prog_divide_in), .reference_disable_bit_in(reference_disable_bit_in),
	.main_divided_output_out(main_divided_output_out),
	.main_divided_output_oe_out(main_divided_output_oe_out),
	.reference_prescaled_output_out(reference_prescaled_output_out),
	.reference_prescaled_output_oe_out(reference_prescaled_output_oe_out),
	.osc_run_out(osc_run_out), .ratios_loaded_out(ratios_loaded_out));

`default_nettype wire
